// [core/cprs_regs.sv]
// Program register set: thirty-two general registers and the instruction pointer.
// Assumes the fetch/execute logic drives ports synchronously to clk_i.
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/10ps
module cprs_regs (
	input wire logic clk_i, // Core clock.
	input wire logic rst_i, // Synchronous reset, high.
	input wire logic [4:0] rd_a_idx_i, // Read port A index.
	output logic [31:0] rd_a_data_o, // Read port A data.
	input wire logic [4:0] rd_b_idx_i, // Read port B index.
	output logic [31:0] rd_b_data_o, // Read port B data.
	input wire logic wr_en_i, // Register write strobe.
	input wire logic [4:0] wr_idx_i, // Register write index.
	input wire logic [31:0] wr_data_i, // Register write data.
	output logic [31:0] element_base_o, // Implicit base pointer.
	output logic [31:0] zero_register_o, // Implicit zero operand.
	output logic [31:0] link_register_o, // Link register contents.
	input wire logic ip_step_i, // Advance pointer by step.
	input wire logic [31:0] ip_step_val_i, // Step or signed offset.
	input wire logic ip_load_i, // Branch: load absolute target.
	input wire logic [31:0] ip_target_i, // Branch target.
	output logic [31:0] instruction_pointer_o, // Current instruction address.
	input wire logic [4:0] reg_addr_i, // Register port address.
	input wire logic [31:0] reg_wdata_i, // Register port write data.
	input wire logic reg_wr_i, // Register port write strobe.
	input wire logic reg_rd_i, // Register port read strobe.
	output logic [31:0] reg_rdata_o // Register port read data.
);
	// ==========================================
	// Storage
	// Register zero has no storage; every read of it is forced to zero below.
	logic [31:0] gpr [1:31];
	// Only the 24 meaningful pointer bits are stored; the top byte is rebuilt as zeros.
	logic [23:0] ip;
	logic [31:0] rdata;
	logic [23:0] next_ip;
	wire port_ip_wr = reg_wr_i && (reg_addr_i == cprs_pkg::OFF_IP);
	wire [23:0] ip_sum = ip + ip_step_val_i[23:0];
	wire gpr_wr = wr_en_i && (wr_idx_i != cprs_pkg::ZERO_REG_IDX);

	// ==========================================
	// Reads
	assign rd_a_data_o = (rd_a_idx_i == cprs_pkg::ZERO_REG_IDX) ? 32'h00000000 : gpr[rd_a_idx_i];
	assign rd_b_data_o = (rd_b_idx_i == cprs_pkg::ZERO_REG_IDX) ? 32'h00000000 : gpr[rd_b_idx_i];
	assign zero_register_o = 32'h00000000;
	assign element_base_o = gpr[cprs_pkg::ELEMENT_BASE_IDX];
	assign link_register_o = gpr[cprs_pkg::LINK_REG_IDX];
	assign instruction_pointer_o = {8'h00, ip} & cprs_pkg::IP_MASK;
	assign reg_rdata_o = rdata;

	// ==========================================
	// Instruction pointer
	// Branch loads win over steps, and steps win over software writes through the port.
	always_comb begin
		next_ip = ip;
		if (ip_load_i) begin
			next_ip = ip_target_i[23:0];
		end else if (ip_step_i) begin
			next_ip = ip_sum;
		end else if (port_ip_wr) begin
			next_ip = reg_wdata_i[23:0];
		end
		next_ip[0] = 1'b0;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ip <= cprs_pkg::IP_RESET[23:0];
		end else begin
			ip <= next_ip;
		end
	end

	// ==========================================
	// General registers
	always_ff @(posedge clk_i) begin
		if (gpr_wr) begin
			gpr[wr_idx_i] <= wr_data_i;
		end
	end

	// ==========================================
	// Register port read data, valid one cycle after the strobe.
	// Unmapped addresses and idle cycles return zero, so stale data never lingers on the port.
	wire port_hit_ip = reg_addr_i == cprs_pkg::OFF_IP;
	wire port_hit_base = reg_addr_i == cprs_pkg::OFF_BASE;
	wire port_hit_link = reg_addr_i == cprs_pkg::OFF_LINK;
	wire [31:0] port_word = port_hit_ip ? instruction_pointer_o :
		port_hit_base ? element_base_o :
		port_hit_link ? link_register_o :
		32'h00000000;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata <= 32'h00000000;
		end else if (reg_rd_i) begin
			rdata <= port_word;
		end else begin
			rdata <= 32'h00000000;
		end
	end

	// ==========================================
	// Check helpers
	// The last accepted write is held for one cycle so the write check can look at storage afterwards.
	logic chk_wr_seen;
	logic [4:0] chk_wr_idx;
	logic [31:0] chk_wr_data;

	always_ff @(posedge clk_i) begin
		chk_wr_seen <= gpr_wr;
		chk_wr_idx <= wr_idx_i;
		chk_wr_data <= wr_data_i;
	end

	// ==========================================
	// Pointer checks
	ip_high_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		instruction_pointer_o[31:24] == 8'h00)
		else $error("pointer high bits set");

	ip_even_a: assert property (@(posedge clk_i) disable iff (rst_i)
		instruction_pointer_o[0] == 1'b0)
		else $error("pointer odd");

	ip_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ip_step_i && !ip_load_i |=> instruction_pointer_o[23:0] ==
		(($past(instruction_pointer_o[23:0]) + $past(ip_step_val_i[23:0])) & cprs_pkg::IP_MASK[23:0]))
		else $error("pointer step wrong");

	ip_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ip_load_i |=> instruction_pointer_o == ($past(ip_target_i) & cprs_pkg::IP_MASK))
		else $error("branch wrong");

	ip_port_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		port_ip_wr && !ip_load_i && !ip_step_i |=>
		instruction_pointer_o == ({8'h00, $past(reg_wdata_i[23:0])} & cprs_pkg::IP_MASK))
		else $error("pointer port write wrong");

	ip_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!ip_load_i && !ip_step_i && !port_ip_wr |=> $stable(instruction_pointer_o))
		else $error("pointer drift");

	// Checked without the reset guard, since the reset itself is what is watched here.
	ip_reset_a: assert property (@(posedge clk_i)
		rst_i |=> instruction_pointer_o == cprs_pkg::IP_RESET)
		else $error("pointer reset wrong");

	// ==========================================
	// Register checks
	zero_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_a_idx_i == cprs_pkg::ZERO_REG_IDX |-> rd_a_data_o == 32'h00000000)
		else $error("zero reg nonzero on port a");

	zero_read_b_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_b_idx_i == cprs_pkg::ZERO_REG_IDX |-> rd_b_data_o == 32'h00000000)
		else $error("zero reg nonzero on port b");

	zero_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_en_i && wr_idx_i == cprs_pkg::ZERO_REG_IDX |-> !gpr_wr)
		else $error("zero reg write accepted");

	zero_implicit_a: assert property (@(posedge clk_i) disable iff (rst_i)
		zero_register_o == 32'h00000000)
		else $error("implicit zero wrong");

	gpr_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		chk_wr_seen |-> gpr[chk_wr_idx] == chk_wr_data)
		else $error("register write lost");

	base_ptr_a: assert property (@(posedge clk_i) disable iff (rst_i)
		gpr_wr && wr_idx_i == cprs_pkg::ELEMENT_BASE_IDX |=> element_base_o == $past(wr_data_i))
		else $error("base pointer wrong");

	link_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		gpr_wr && wr_idx_i == cprs_pkg::LINK_REG_IDX |=> link_register_o == $past(wr_data_i))
		else $error("link register wrong");

	// ==========================================
	// Register port checks
	rdata_ip_a: assert property (@(posedge clk_i) disable iff (rst_i)
		reg_rd_i && port_hit_ip |=> reg_rdata_o == $past(instruction_pointer_o))
		else $error("port pointer read wrong");

	rdata_base_a: assert property (@(posedge clk_i) disable iff (rst_i)
		reg_rd_i && port_hit_base |=> reg_rdata_o == $past(element_base_o))
		else $error("port base read wrong");

	rdata_link_a: assert property (@(posedge clk_i) disable iff (rst_i)
		reg_rd_i && port_hit_link |=> reg_rdata_o == $past(link_register_o))
		else $error("port link read wrong");

	port_base_ro_a: assert property (@(posedge clk_i) disable iff (rst_i)
		reg_wr_i && port_hit_base && !(gpr_wr && wr_idx_i == cprs_pkg::ELEMENT_BASE_IDX) |=> $stable(element_base_o))
		else $error("port wrote base pointer");

	rdata_unmapped_a: assert property (@(posedge clk_i) disable iff (rst_i)
		reg_rd_i && !port_hit_ip && !port_hit_base && !port_hit_link |=> reg_rdata_o == 32'h00000000)
		else $error("unmapped read nonzero");

	rdata_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!reg_rd_i |=> reg_rdata_o == 32'h00000000)
		else $error("port data lingered");

	// ==========================================
	// Coverage of the main scenarios
	step_cover_c: cover property (@(posedge clk_i) disable iff (rst_i)
		ip_step_i ##1 ip_step_i);
	wrap_cover_c: cover property (@(posedge clk_i) disable iff (rst_i)
		ip_step_i && ip_sum < ip);
	branch_cover_c: cover property (@(posedge clk_i) disable iff (rst_i)
		ip_load_i && ip_target_i[0]);
	zero_write_c: cover property (@(posedge clk_i) disable iff (rst_i)
		wr_en_i && wr_idx_i == cprs_pkg::ZERO_REG_IDX);
	port_read_c: cover property (@(posedge clk_i) disable iff (rst_i)
		reg_rd_i && port_hit_ip);
endmodule

// [core/cprs_pkg.sv]
// Constants shared by the program register set of the core.
// Assumes a single 50 MHz clock and a synchronous active-high reset.
package cprs_pkg;
	localparam int DATA_W = 32;
	localparam int REG_COUNT = 32;
	localparam int IDX_W = 5;
	localparam int IP_VALID_W = 24;
	localparam logic [4:0] ZERO_REG_IDX = 5'h00;
	localparam logic [4:0] ELEMENT_BASE_IDX = 5'h1e;
	localparam logic [4:0] LINK_REG_IDX = 5'h1f;
	localparam logic [31:0] IP_RESET = 32'h00000000;
	localparam logic [31:0] IP_MASK = 32'h00fffffe;
	localparam logic [4:0] OFF_IP = 5'h00;
	localparam logic [4:0] OFF_BASE = 5'h01;
	localparam logic [4:0] OFF_LINK = 5'h02;
endpackage

// [test/cprs_fetch_model.sv]
// Fetch/execute stand-in that turns bench requests into pointer pulses.
// Assumes requests change just after a rising edge of clk_i.
`timescale 1ns/10ps
module cprs_fetch_model (
	input wire logic clk_i, // Core clock.
	input wire logic [1:0] req_i, // 1 load, 2 step, 0 idle.
	input wire logic [31:0] val_i, // Target or step.
	output logic ip_load_o, // Load pulse.
	output logic ip_step_o, // Step pulse.
	output logic [31:0] val_o // Value to the pointer.
);
	// Idle cycles show the inverse of the bench value, so a stale target is never mistaken for a live one.
	always_ff @(posedge clk_i) begin
		ip_load_o <= req_i == 2'h1;
		ip_step_o <= req_i == 2'h2;
		val_o <= (req_i != 2'h0) ? val_i : ~val_i;
	end
endmodule

// [test/test_cpu_program_register_set.sv]
// Bench for the program register set: random register traffic and pointer moves.
// Assumes the fetch model drives the pointer controls.
`timescale 1ns/10ps
module test_cpu_program_register_set;
	logic clk_i = 1'b0, rst_i = 1'b1, we = 1'b0, pw = 1'b0, pr = 1'b0, ld, st;
	logic [1:0] rq = 2'h0;
	logic [4:0] ia = 5'h00, ib = 5'h00, wi = 5'h00, pa = 5'h00;
	logic [31:0] wd = 32'h0, pd = 32'h0, pv = 32'h0, da, db, eb, zr, lr, ip, rd, tg, xp;
	logic [31:0] gpr [32];
	int mismatches = 0, num_checks = 0, seed = 32'h02056fed, k;
	always #10 clk_i = ~clk_i;
	cprs_fetch_model fm_u (.clk_i(clk_i), .req_i(rq), .val_i(pv), .ip_load_o(ld), .ip_step_o(st), .val_o(tg));
	cprs_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .rd_a_idx_i(ia), .rd_a_data_o(da), .rd_b_idx_i(ib),
		.rd_b_data_o(db), .wr_en_i(we), .wr_idx_i(wi), .wr_data_i(wd), .element_base_o(eb), .zero_register_o(zr),
		.link_register_o(lr), .ip_step_i(st), .ip_step_val_i(tg), .ip_load_i(ld), .ip_target_i(tg),
		.instruction_pointer_o(ip), .reg_addr_i(pa), .reg_wdata_i(pd), .reg_wr_i(pw), .reg_rd_i(pr), .reg_rdata_o(rd));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic ptr(input logic [1:0] r, input logic [31:0] v);
		@(posedge clk_i);
		pv <= v;
		rq <= r;
		@(posedge clk_i);
		rq <= 2'h0;
		xp = ((r == 2'h1) ? v : xp + v) & cprs_pkg::IP_MASK;
		repeat (2) @(posedge clk_i);
		#1 chk("pointer", xp, ip);
	endtask
	task automatic prd(input logic w, input logic [4:0] a, input logic [31:0] e);
		@(posedge clk_i);
		pw <= w;
		pr <= !w;
		pa <= a;
		pd <= 32'hffffffff;
		@(posedge clk_i);
		pw <= 1'b0;
		pr <= 1'b0;
		#1 if (!w) chk("port read", e, rd);
		@(posedge clk_i);
		#1 chk("port idle", 32'h0, rd);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#50000 mismatches++;
		$display("mismatch watchdog expected finish seen timeout");
		tally_and_finish();
	end
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		#1 chk("pointer reset", 32'h0, ip);
		for (k = 0; k < 32; k++) begin
			@(posedge clk_i);
			xp = $random(seed);
			wi <= k[4:0];
			wd <= xp;
			we <= 1'b1;
			gpr[k] = (k == 0) ? 32'h0 : xp;
		end
		@(posedge clk_i);
		we <= 1'b0;
		for (k = 0; k < 32; k++) begin
			@(posedge clk_i);
			xp = $random(seed);
			ia <= k[4:0];
			ib <= xp[4:0];
			#1 chk("read a", gpr[ia], da);
			chk("read b", gpr[ib], db);
		end
		chk("base", gpr[30], eb);
		chk("zero", 32'h0, zr);
		chk("link", gpr[31], lr);
		$display("registers done");
		ptr(2'h1, 32'hffffffff);
		for (k = 0; k < 8; k++) ptr(2'h1, $random(seed));
		ptr(2'h1, 32'h00fffffe);
		ptr(2'h2, 32'h00000004);
		for (k = 0; k < 8; k++) ptr(2'h2, $random(seed));
		$display("pointer done");
		prd(1'b0, cprs_pkg::OFF_IP, xp);
		prd(1'b1, cprs_pkg::OFF_IP, 32'h0);
		prd(1'b0, cprs_pkg::OFF_IP, cprs_pkg::IP_MASK);
		prd(1'b1, cprs_pkg::OFF_BASE, 32'h0);
		prd(1'b0, cprs_pkg::OFF_BASE, gpr[30]);
		prd(1'b0, 5'h1f, 32'h0);
		$display("port done");
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		#1 chk("pointer reset again", cprs_pkg::IP_RESET, ip);
		chk("base kept", gpr[30], eb);
		prd(1'b0, cprs_pkg::OFF_LINK, gpr[31]);
		$display("reset done");
		tally_and_finish();
	end
endmodule
